/* File: logic/paiou_alu.sv */
// Word and integer arithmetic of the advanced instruction operand unit
`timescale 1ns/100ps

module paiou_alu (
    // Operation select
    input  wire paiou_pkg::paiou_op_type    op,
    input  wire paiou_pkg::paiou_dtype_type dtype,
    // Operands
    input  wire logic [15:0]                a,
    input  wire logic [15:0]                b,
    // Result
    output paiou_pkg::paiou_alu_res_type    res
);
    import paiou_pkg::*;

    // Seventeen bit sign or zero extension, shared by add and subtract
    function automatic logic [16:0] ext17(input logic [15:0] v, input logic sgn);
        return {sgn & v[15], v};
    endfunction

    logic        sgn;
    logic [16:0] sum;
    logic [16:0] dif;
    logic        ovf_add;
    logic        ovf_sub;
    logic [15:0] quo;
    logic [15:0] rem;

    assign sgn = (dtype == DT_INT);
    assign sum = 17'(ext17(a, sgn) + ext17(b, sgn));
    assign dif = 17'(ext17(a, sgn) - ext17(b, sgn));
    // Signed overflow shows as the two top bits parting
    assign ovf_add = sgn ? (sum[16] != sum[15]) : sum[16];
    assign ovf_sub = sgn ? (dif[16] != dif[15]) : (a < b);
    assign quo = (b == 16'h0000) ? 16'h0000 :
                 sgn ? 16'($signed(a) / $signed(b)) : 16'(a / b);
    assign rem = (b == 16'h0000) ? 16'h0000 :
                 sgn ? 16'($signed(a) % $signed(b)) : 16'(a % b);

    // Results wrap to sixteen bits; flags tell the program it happened
    always_comb begin
        res = '0;
        unique case (op)
            OP_ADD: begin
                res.lo    = sum[15:0];
                res.carry = ovf_add;
            end
            OP_SUB: begin
                res.lo     = dif[15:0];
                res.borrow = ovf_sub;
            end
            OP_DIV: begin
                res.lo   = quo;
                res.hi   = rem;
                res.div0 = (b == 16'h0000);
            end
            OP_AND:  res.lo = a & b;
            default: res.lo = a;
        endcase
    end

endmodule // paiou_alu

/* File: logic/paiou_defines.svh */
// Offsets, area limits, reset values and counts of the advanced instruction operand unit
`ifndef PAIOU_DEFINES_SVH
`define PAIOU_DEFINES_SVH

// Repeat count limits, accepted range is 1 through 99
`define PAIOU_REP_MIN      7'h01
`define PAIOU_REP_MAX      7'h63

// Points per word of a bit operand
`define PAIOU_BIT_PTS      18'h0_0010

// Last valid linear point or word index of each operand area
`define PAIOU_END_IN       18'h0_00FF
`define PAIOU_END_OUT      18'h0_00F7
`define PAIOU_END_MR       18'h0_03FF
`define PAIOU_END_SMR      18'h0_007F
`define PAIOU_END_SR       18'h0_00FF
`define PAIOU_END_TMR      18'h0_00FF
`define PAIOU_END_CNT      18'h0_00FF
`define PAIOU_END_DR       18'h0_0513
`define PAIOU_END_DX       18'h0_176F
`define PAIOU_END_DS       18'h0_00C7

// Reset values
`define PAIOU_WORD_RST     16'h0000
`define PAIOU_ITER_RST     7'h00

`endif

/* File: logic/paiou_exec_unit.sv */
// Scan-time operand and execution control of the advanced instructions
//
// What the document says
// RQ1: Each operand has repeat flag and count; counts outside 1..99 are rejected.
// RQ2: Instruction carries a data type choosing unsigned word or signed integer.
// RQ3: Source operands give 16-bit values; a second source is supported.
// RQ4: Destinations take 16-bit results; division writes two consecutive words.
// RQ5: Program puts a contact before every instruction but a few exceptions.
// RQ6: Instruction runs on every scan while its input condition is true.
// RQ7: False input condition skips the instruction, leaving operands unchanged.
// RQ8: Program uses edge single-output elements to run only once per transition.
// RQ9: A bit operand means sixteen consecutive points taken as one word.
// RQ10: Timer or counter source gives current value; data registers read directly.
// RQ11: Timer or counter destination receives the result as its preset.
// RQ12: Timers count down from preset, so their value is remaining time.
// RQ13: Adding counters count up from zero; reversible ones move from preset.
// RQ14: Destination timer or counter preset set by register gives execution error.
// RQ15: Type choice only for move, compare, arithmetic; others fixed word or integer.
// RQ16: Word is 0..65535, integer is 16-bit two's complement, one register each.
// RQ17: Word add over 65535 sets carry; subtract below zero sets borrow.
// RQ18: Integer overflow sets carry or borrow and keeps the wrapped pattern.
// RQ19: Operand areas are separate with their own ends, never running over.
// RQ20: Any operand span past its area end is rejected as syntax error.
// RQ21: Repeated bit operands step by sixteen points; out-of-area steps are invalid.
// RQ22: No-operation does nothing, needs no contact or operand, just takes time.
// RQ23: Carry, borrow and execution error are latched for the program to read.
`timescale 1ns/100ps
`include "paiou_defines.svh"

module paiou_exec_unit (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    // Scan request
    input  wire logic                       scan_start,
    input  wire paiou_pkg::paiou_instr_type instr,
    input  wire logic                       input_cond,
    // Operand reads, answered in the same cycle
    output paiou_pkg::paiou_ref_type        rd1_ref,
    input  wire logic [15:0]                rd1_data,
    output paiou_pkg::paiou_ref_type        rd2_ref,
    input  wire logic [15:0]                rd2_data,
    // Destination preset source lookup
    output paiou_pkg::paiou_ref_type        dst_ref,
    input  wire logic                       dst_preset_from_dr,
    // Operand writes
    output paiou_pkg::paiou_wr_type         wr_q,
    // Status
    output logic                            busy,
    output logic                            done_q,
    output logic                            carry_flag_q,
    output logic                            borrow_flag_q,
    output logic                            exec_err_q,
    output logic                            syntax_err_q
);
    import paiou_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HI, ST_GAP} paiou_state_type;

    paiou_state_type   st_q;
    paiou_state_type   st_d;
    paiou_instr_type   ins_q;
    logic [6:0]        iter_q;
    logic [6:0]        n_q;
    logic [15:0]       hi_q;
    paiou_alu_res_type res;
    paiou_dtype_type   eff_type;
    logic              two_src;
    logic              two_dst;
    logic              ok1;
    logic              ok2;
    logic              okd;
    logic              span_ok;
    logic [6:0]        n_cyc;
    logic              accept;
    logic              take;
    logic              last_iter;
    logic              tc_dst;
    logic              run_err;
    logic              run_wr;
    paiou_ref_type     dst_hi_ref;

    // Address of an operand in a given cycle, sixteen points per step for bits
    function automatic paiou_ref_type opnd_at(input paiou_opnd_type o,
                                              input logic [6:0] it,
                                              input logic pair, input logic hi);
        logic [15:0] step;
        logic [15:0] idx;
        step = is_bit(o.area) ? 16'h0010 : 16'h0001;
        idx  = o.rep_on ? 16'(it) : 16'h0000;
        if (pair) begin
            idx = 16'(idx * 16'h0002);
        end
        opnd_at.area = o.area;
        if (o.area == AREA_CONST) begin
            opnd_at.addr = o.addr;
        end else begin
            opnd_at.addr = 16'(o.addr + idx * step + (hi ? step : 16'h0000));
        end
    endfunction

    // Larger of two cycle counts
    function automatic logic [6:0] max7(input logic [6:0] x, input logic [6:0] y);
        return (x > y) ? x : y;
    endfunction

    // Operand shape of the requested instruction
    assign two_src = instr.op inside {OP_ADD, OP_SUB, OP_DIV, OP_AND}; // RQ3
    assign two_dst = (instr.op == OP_DIV); // RQ4

    // Span checks run on the incoming instruction before anything is touched
    paiou_range_check u_chk_src1 (
        .opnd     (instr.src1),
        .is_dst   (1'b0),
        .two_word (1'b0),
        .in_range (ok1)
    );

    paiou_range_check u_chk_src2 (
        .opnd     (instr.src2),
        .is_dst   (1'b0),
        .two_word (1'b0),
        .in_range (ok2)
    );

    paiou_range_check u_chk_dst (
        .opnd     (instr.dst),
        .is_dst   (1'b1),
        .two_word (two_dst),
        .in_range (okd)
    );

    // Repeat cycles are the longest of the operands that repeat
    assign span_ok = ok1 && okd && (ok2 || !two_src); // RQ1 RQ19 RQ20 RQ21
    assign n_cyc   = max7(max7(rep_of(instr.src1), rep_of(instr.dst)),
                          two_src ? rep_of(instr.src2) : 7'h01);

    // A scan request is only seen while idle; no-operation needs no contact
    assign accept = (st_q == ST_IDLE) && scan_start;
    assign take   = accept && (instr.op != OP_NOP) && input_cond && span_ok; // RQ6 RQ7 RQ22

    // Type select only for move and arithmetic; others are fixed
    always_comb begin
        unique case (ins_q.op)
            OP_MOV, OP_ADD, OP_SUB, OP_DIV: eff_type = ins_q.dtype; // RQ2 RQ15
            OP_XYC:                         eff_type = DT_INT; // RQ15
            default:                        eff_type = DT_WORD; // RQ15 RQ16
        endcase
    end

    // Current references; bit areas give sixteen points as one word
    // Timer counting direction is the timer's own; its value passes through as is
    assign rd1_ref = opnd_at(ins_q.src1, iter_q, 1'b0, 1'b0); // RQ9 RQ10 RQ21 RQ12 RQ13
    assign rd2_ref = opnd_at(ins_q.src2, iter_q, 1'b0, 1'b0); // RQ3
    assign dst_ref = opnd_at(ins_q.dst, iter_q, ins_q.op == OP_DIV, 1'b0); // RQ4 RQ21
    // Second result word sits one step past the first
    assign dst_hi_ref = opnd_at(ins_q.dst, iter_q, 1'b1, 1'b1); // RQ4

    paiou_alu u_alu (
        .op    (ins_q.op),
        .dtype (eff_type),
        .a     (rd1_data),
        .b     (rd2_data),
        .res   (res)
    );

    // A timer or counter whose preset comes from a register cannot be written
    assign tc_dst    = ins_q.dst.area inside {AREA_TMR, AREA_CNT}; // RQ11
    assign run_err   = (st_q == ST_RUN) &&
                       ((tc_dst && dst_preset_from_dr) || res.div0); // RQ14
    assign run_wr    = (st_q == ST_RUN) && !run_err;
    assign last_iter = (iter_q == 7'(n_q - 7'h01));
    assign busy      = (st_q != ST_IDLE);

    // Each cycle waits one gap so overlapped repeats read fresh data
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (take) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (run_err) begin
                    st_d = ST_IDLE;
                end else if (ins_q.op == OP_DIV) begin
                    st_d = ST_HI;
                end else begin
                    st_d = ST_GAP;
                end
            end
            ST_HI: st_d = ST_GAP;
            ST_GAP: begin
                st_d = last_iter ? ST_IDLE : ST_RUN;
            end
        endcase
    end

    // State, instruction and cycle count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= ST_IDLE;
            ins_q  <= '0;
            iter_q <= `PAIOU_ITER_RST;
            n_q    <= `PAIOU_ITER_RST;
        end else begin
            st_q <= st_d;
            if (take) begin
                ins_q  <= instr;
                iter_q <= `PAIOU_ITER_RST;
                n_q    <= n_cyc;
            end else if (st_q == ST_GAP) begin
                iter_q <= 7'(iter_q + 7'h01);
            end
        end
    end

    // Remainder kept for the second destination word
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_q <= `PAIOU_WORD_RST;
        end else if (st_q == ST_RUN) begin
            hi_q <= res.hi;
        end
    end

    // Registered write port; nothing is written on skip, error or no-operation
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
        end else if (run_wr) begin
            wr_q <= {1'b1, dst_ref.area, dst_ref.addr, res.lo}; // RQ4 RQ11 RQ17 RQ18
        end else if (st_q == ST_HI) begin
            wr_q <= {1'b1, ins_q.dst.area,
                     dst_hi_ref.addr, hi_q}; // RQ4
        end else begin
            wr_q <= '0; // RQ7
        end
    end

    // Flags clear when an instruction starts and latch any event after that
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            carry_flag_q  <= 1'b0;
            borrow_flag_q <= 1'b0;
            exec_err_q    <= 1'b0;
            syntax_err_q  <= 1'b0;
        end else if (accept && instr.op != OP_NOP && input_cond) begin
            carry_flag_q  <= 1'b0;
            borrow_flag_q <= 1'b0;
            exec_err_q    <= 1'b0;
            syntax_err_q  <= !span_ok; // RQ20
        end else if (st_q == ST_RUN) begin
            carry_flag_q  <= carry_flag_q | res.carry; // RQ17 RQ18 RQ23
            borrow_flag_q <= borrow_flag_q | res.borrow; // RQ17 RQ18 RQ23
            exec_err_q    <= exec_err_q | run_err; // RQ14 RQ23
        end
    end

    // One-cycle completion pulse, also for skips, rejects and no-operation
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (accept && !take) || (busy && st_d == ST_IDLE);
        end
    end

    // Checks on the scan behaviour
    property p_skip;
        @(posedge mclk) disable iff (!rst_n)
        (accept && !input_cond) |=> done_q && !wr_q.en && !busy;
    endproperty
    a_skip: assert property (p_skip) else $error("false condition did not skip"); // RQ7

    property p_nop;
        @(posedge mclk) disable iff (!rst_n)
        (accept && instr.op == OP_NOP) |=> done_q && !wr_q.en ##1 !wr_q.en;
    endproperty
    a_nop: assert property (p_nop) else $error("no-operation acted"); // RQ22

    property p_run;
        @(posedge mclk) disable iff (!rst_n)
        take |=> (st_q == ST_RUN) ##1 (wr_q.en || exec_err_q);
    endproperty
    a_run: assert property (p_run) else $error("true condition did not execute"); // RQ6

    property p_rep_range;
        @(posedge mclk) disable iff (!rst_n)
        (accept && input_cond && instr.op != OP_NOP && instr.dst.rep_on &&
         instr.dst.rep_cnt > 7'h63) |=> syntax_err_q && done_q && !busy;
    endproperty
    a_rep_range: assert property (p_rep_range) else $error("bad repeat accepted"); // RQ1

    property p_word_carry;
        @(posedge mclk) disable iff (!rst_n)
        (st_q == ST_RUN && ins_q.op == OP_ADD && eff_type == DT_WORD &&
         ({1'b0, rd1_data} + {1'b0, rd2_data} > 17'h0_FFFF)) |=> carry_flag_q;
    endproperty
    a_word_carry: assert property (p_word_carry) else $error("carry missed"); // RQ17

    property p_int_borrow;
        @(posedge mclk) disable iff (!rst_n)
        (st_q == ST_RUN && ins_q.op == OP_SUB && eff_type == DT_INT &&
         rd1_data == 16'h8000 && rd2_data == 16'h0001 && !run_err)
        |=> borrow_flag_q && wr_q.data == 16'h7FFF;
    endproperty
    a_int_borrow: assert property (p_int_borrow) else $error("integer borrow wrong"); // RQ18

    property p_exec_err;
        @(posedge mclk) disable iff (!rst_n)
        (st_q == ST_RUN && tc_dst && dst_preset_from_dr)
        |=> exec_err_q && !wr_q.en && done_q;
    endproperty
    a_exec_err: assert property (p_exec_err) else $error("preset write not blocked"); // RQ14

    property p_div_pair;
        @(posedge mclk) disable iff (!rst_n)
        (st_q == ST_RUN && ins_q.op == OP_DIV && !run_err)
        |=> wr_q.en ##1 (wr_q.en && wr_q.addr != $past(wr_q.addr));
    endproperty
    a_div_pair: assert property (p_div_pair) else $error("second word missing"); // RQ4

    property p_done_bound;
        @(posedge mclk) disable iff (!rst_n)
        accept |-> ##[1:310] done_q;
    endproperty
    a_done_bound: assert property (p_done_bound) else $error("instruction never ended"); // RQ6

    property p_span;
        @(posedge mclk) disable iff (!rst_n)
        (accept && input_cond && instr.op != OP_NOP && !span_ok) |=> syntax_err_q && !busy;
    endproperty
    a_span: assert property (p_span) else $error("span not rejected"); // RQ20

    c_repeat: cover property (@(posedge mclk) disable iff (!rst_n)
        take && n_cyc > 7'h02);
    c_div: cover property (@(posedge mclk) disable iff (!rst_n)
        st_q == ST_HI);
    c_syntax: cover property (@(posedge mclk) disable iff (!rst_n)
        accept && input_cond && !span_ok);
    c_exec_err: cover property (@(posedge mclk) disable iff (!rst_n)
        run_err);

endmodule // paiou_exec_unit

/* File: logic/paiou_pkg.sv */
// Types shared by the advanced instruction operand unit
package paiou_pkg;

    typedef enum logic [3:0] {
        AREA_IN, AREA_OUT, AREA_MR, AREA_SMR, AREA_SR,
        AREA_TMR, AREA_CNT, AREA_DR, AREA_DX, AREA_DS, AREA_CONST
    } paiou_area_type;

    typedef enum logic [2:0] {
        OP_NOP, OP_MOV, OP_ADD, OP_SUB, OP_DIV, OP_AND, OP_XYC
    } paiou_op_type;

    typedef enum logic {DT_WORD, DT_INT} paiou_dtype_type;

    typedef struct packed {
        paiou_area_type area;
        logic [15:0]    addr;
        logic           rep_on;
        logic [6:0]     rep_cnt;
    } paiou_opnd_type;

    typedef struct packed {
        paiou_op_type    op;
        paiou_dtype_type dtype;
        paiou_opnd_type  src1;
        paiou_opnd_type  src2;
        paiou_opnd_type  dst;
    } paiou_instr_type;

    typedef struct packed {
        paiou_area_type area;
        logic [15:0]    addr;
    } paiou_ref_type;

    typedef struct packed {
        logic           en;
        paiou_area_type area;
        logic [15:0]    addr;
        logic [15:0]    data;
    } paiou_wr_type;

    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
        logic        carry;
        logic        borrow;
        logic        div0;
    } paiou_alu_res_type;

    // Bit areas are addressed in points and taken sixteen at a time
    function automatic logic is_bit(input paiou_area_type a);
        return (a == AREA_IN) || (a == AREA_OUT) || (a == AREA_MR) ||
               (a == AREA_SMR) || (a == AREA_SR);
    endfunction

    // Cycles an operand asks for, one when repeat is off
    function automatic logic [6:0] rep_of(input paiou_opnd_type o);
        return o.rep_on ? o.rep_cnt : 7'h01;
    endfunction

endpackage

/* File: logic/paiou_range_check.sv */
// Span check of one operand against the end of its own area
`timescale 1ns/100ps
`include "paiou_defines.svh"

module paiou_range_check (
    // Operand under test
    input  wire paiou_pkg::paiou_opnd_type opnd,
    input  wire logic                      is_dst,
    input  wire logic                      two_word,
    // Verdict
    output logic                           in_range
);
    import paiou_pkg::*;

    logic [17:0] area_end;
    logic [17:0] units;
    logic [17:0] pts;
    logic [17:0] last;
    logic        cnt_ok;
    logic        dst_ok;

    // Areas never run into each other, so each has its own end
    always_comb begin
        unique case (opnd.area)
            AREA_IN:  area_end = `PAIOU_END_IN;
            AREA_OUT: area_end = `PAIOU_END_OUT;
            AREA_MR:  area_end = `PAIOU_END_MR;
            AREA_SMR: area_end = `PAIOU_END_SMR;
            AREA_SR:  area_end = `PAIOU_END_SR;
            AREA_TMR: area_end = `PAIOU_END_TMR;
            AREA_CNT: area_end = `PAIOU_END_CNT;
            AREA_DR:  area_end = `PAIOU_END_DR;
            AREA_DX:  area_end = `PAIOU_END_DX;
            AREA_DS:  area_end = `PAIOU_END_DS;
            default:  area_end = 18'h3_FFFF;
        endcase
    end

    // Whole span: every repeat cycle, each with a second result word when two are written
    assign cnt_ok = !opnd.rep_on ||
                    (opnd.rep_cnt >= `PAIOU_REP_MIN && opnd.rep_cnt <= `PAIOU_REP_MAX);
    assign units  = 18'(rep_of(opnd)) * (two_word ? 18'h0_0002 : 18'h0_0001);
    assign pts    = is_bit(opnd.area) ? 18'(units * `PAIOU_BIT_PTS) : units;
    assign last   = 18'({2'b00, opnd.addr} + pts - 18'h0_0001);
    // Inputs, special relays and constants cannot take a result
    assign dst_ok = !is_dst || !(opnd.area inside {AREA_IN, AREA_SMR, AREA_CONST});
    assign in_range = cnt_ok && dst_ok &&
                      ((opnd.area == AREA_CONST) || (last <= area_end));

endmodule // paiou_range_check

/* File: test/paiou_mem_model.sv */
// Operand memory model answering the operand unit's reads and writes
`timescale 1ns/100ps
module paiou_mem_model
    import paiou_pkg::*;
#(
    parameter logic [15:0] PRESET_DR_IDX = 16'h0007
) (
    // Clock
    input  wire logic          mclk,
    // Reads and preset lookup
    input  wire paiou_ref_type rd1_ref,
    output logic [15:0]        rd1_data,
    input  wire paiou_ref_type rd2_ref,
    output logic [15:0]        rd2_data,
    input  wire paiou_ref_type dst_ref,
    output logic               dst_preset_from_dr,
    // Writes
    input  wire paiou_wr_type  wr_q
);
    logic [15:0] mem [int];
    int          n_wr = 0;

    // Unwritten places read a pattern, so a stale value cannot look right
    function automatic logic [15:0] peek(input paiou_ref_type r);
        int k;
        k = int'({r.area, r.addr});
        if (r.area == AREA_CONST) return r.addr;
        return mem.exists(k) ? mem[k] : ~r.addr;
    endfunction

    // Same-cycle reads; bit areas stored as whole words at the start point
    always @(rd1_ref, rd2_ref, n_wr) begin
        rd1_data = peek(rd1_ref);
        rd2_data = peek(rd2_ref);
    end

    // One timer slot and one counter slot have their presets held in a data register
    assign dst_preset_from_dr = (dst_ref.area inside {AREA_TMR, AREA_CNT}) &&
                                (dst_ref.addr == PRESET_DR_IDX);

    // Apply each write pulse; timer and counter writes land as presets
    always @(posedge mclk) begin
        if (wr_q.en === 1'b1) begin
            mem[int'({wr_q.area, wr_q.addr})] = wr_q.data;
            n_wr++;
        end
    end
endmodule // paiou_mem_model

/* File: test/test_plc_advanced_instr_operand_unit.sv */
// Self-checking bench of the advanced instruction operand unit
`timescale 1ns/100ps
module test_plc_advanced_instr_operand_unit;
    import paiou_pkg::*;
    logic            mclk = 1'b0;
    logic            rst_n = 1'b0;
    logic            scan_start = 1'b0;
    logic            input_cond = 1'b0;
    paiou_instr_type instr = '0;
    paiou_ref_type   rd1_ref, rd2_ref, dst_ref;
    logic [15:0]     rd1_data, rd2_data;
    logic            dst_preset_from_dr, busy, done_q;
    logic            carry_flag_q, borrow_flag_q, exec_err_q, syntax_err_q;
    paiou_wr_type    wr_q;
    int              n_errors = 0;
    int              n_compared = 0;
    paiou_opnd_type  k1, z;

    // 10 MHz clock
    always #50 mclk = ~mclk;

    paiou_exec_unit u_paiou_exec_unit (.mclk(mclk), .rst_n(rst_n),
        .scan_start(scan_start), .instr(instr), .input_cond(input_cond),
        .rd1_ref(rd1_ref), .rd1_data(rd1_data), .rd2_ref(rd2_ref),
        .rd2_data(rd2_data), .dst_ref(dst_ref),
        .dst_preset_from_dr(dst_preset_from_dr), .wr_q(wr_q), .busy(busy),
        .done_q(done_q), .carry_flag_q(carry_flag_q),
        .borrow_flag_q(borrow_flag_q), .exec_err_q(exec_err_q),
        .syntax_err_q(syntax_err_q));
    paiou_mem_model u_paiou_mem_model (.mclk(mclk), .rd1_ref(rd1_ref),
        .rd1_data(rd1_data), .rd2_ref(rd2_ref), .rd2_data(rd2_data),
        .dst_ref(dst_ref), .dst_preset_from_dr(dst_preset_from_dr), .wr_q(wr_q));

    function automatic paiou_opnd_type od(paiou_area_type a, logic [15:0] ad,
                                          logic r = 1'b0, logic [6:0] c = 7'h01);
        return '{a, ad, r, c};
    endfunction

    function automatic logic [15:0] mem_at(paiou_area_type a, logic [15:0] ad);
        return u_paiou_mem_model.peek('{a, ad});
    endfunction

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // One request, then count edges until done; checks writes seen too
    task automatic run(input paiou_op_type op, input paiou_dtype_type dt,
                       input paiou_opnd_type s1, s2, d, input logic c,
                       input int cyc, input int wrs);
        int i;
        int w;
        w = u_paiou_mem_model.n_wr;
        @(posedge mclk);
        instr <= '{op, dt, s1, s2, d};
        input_cond <= c;
        scan_start <= 1'b1;
        @(posedge mclk);
        scan_start <= 1'b0;
        i = 1;
        #1;
        while (done_q !== 1'b1 && i < 400) begin
            @(posedge mclk);
            #1;
            i++;
        end
        chk16(16'(i), 16'(cyc));
        chk1(busy, 1'b0);
        chk16(16'(u_paiou_mem_model.n_wr - w), 16'(wrs));
    endtask

    task automatic end_of_test;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog, far beyond the fewer than a hundred cycles the tests need
    initial begin
        #2_000_000;
        n_errors++;
        end_of_test;
    end

    initial begin
        z = od(AREA_CONST, 16'h0000);
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        k1 = od(AREA_CONST, 16'h0001);
        run(OP_MOV, DT_WORD, od(AREA_DR, 16'h000A), z, od(AREA_DR, 16'h0014), 1'b1, 3, 1);
        chk16(mem_at(AREA_DR, 16'h0014), ~16'h000A);
        run(OP_MOV, DT_WORD, k1, z, od(AREA_DR, 16'h0014), 1'b0, 1, 0);
        chk16(mem_at(AREA_DR, 16'h0014), ~16'h000A);
        run(OP_NOP, DT_WORD, z, z, z, 1'b0, 1, 0);
        run(OP_ADD, DT_WORD, od(AREA_CONST, 16'hFFFF), k1, od(AREA_DR, 16'h001E), 1'b1, 3, 1);
        chk16(mem_at(AREA_DR, 16'h001E), 16'h0000);
        chk1(carry_flag_q, 1'b1);
        run(OP_SUB, DT_WORD, z, k1, od(AREA_DR, 16'h001E), 1'b1, 3, 1);
        chk16(mem_at(AREA_DR, 16'h001E), 16'hFFFF);
        chk1(borrow_flag_q, 1'b1);
        chk1(carry_flag_q, 1'b0);
        run(OP_ADD, DT_INT, od(AREA_CONST, 16'h7FFF), k1, od(AREA_DR, 16'h001F), 1'b1, 3, 1);
        chk16(mem_at(AREA_DR, 16'h001F), 16'h8000);
        chk1(carry_flag_q, 1'b1);
        run(OP_SUB, DT_INT, od(AREA_CONST, 16'h8000), k1, od(AREA_DR, 16'h001F), 1'b1, 3, 1);
        chk16(mem_at(AREA_DR, 16'h001F), 16'h7FFF);
        chk1(borrow_flag_q, 1'b1);
        run(OP_DIV, DT_WORD, od(AREA_CONST, 16'h0007), od(AREA_CONST, 16'h0002), od(AREA_DR, 16'h0028), 1'b1, 4, 2);
        chk16(mem_at(AREA_DR, 16'h0028), 16'h0003);
        chk16(mem_at(AREA_DR, 16'h0029), 16'h0001);
        run(OP_DIV, DT_WORD, k1, k1, od(AREA_DR, 16'h0513), 1'b1, 1, 0);
        chk1(syntax_err_q, 1'b1);
        run(OP_MOV, DT_WORD, k1, z, od(AREA_MR, 16'h03F0), 1'b1, 3, 1);
        chk1(syntax_err_q, 1'b0);
        run(OP_MOV, DT_WORD, k1, z, od(AREA_MR, 16'h03F8), 1'b1, 1, 0);
        chk1(syntax_err_q, 1'b1);
        // Repeat counts just outside the accepted limits, 0 and 100
        for (int i = 0; i < 2; i++) begin
            run(OP_MOV, DT_WORD, k1, z, od(AREA_DR, 16'h0032, 1'b1, i ? 7'h64 : 7'h00), 1'b1, 1, 0);
            chk1(syntax_err_q, 1'b1);
        end
        run(OP_MOV, DT_WORD, od(AREA_CONST, 16'h0005), z, od(AREA_DR, 16'h0032, 1'b1, 7'h03), 1'b1, 7, 3);
        chk16(mem_at(AREA_DR, 16'h0034), 16'h0005);
        run(OP_MOV, DT_WORD, k1, z, od(AREA_OUT, 16'h00E8, 1'b1, 7'h02), 1'b1, 1, 0);
        chk1(syntax_err_q, 1'b1);
        run(OP_MOV, DT_WORD, k1, z, od(AREA_OUT, 16'h00D8, 1'b1, 7'h02), 1'b1, 5, 2);
        chk16(mem_at(AREA_OUT, 16'h00E8), 16'h0001);
        run(OP_MOV, DT_WORD, k1, z, od(AREA_TMR, 16'h0007), 1'b1, 2, 0);
        chk1(exec_err_q, 1'b1);
        run(OP_MOV, DT_WORD, od(AREA_CONST, 16'h0009), z, od(AREA_TMR, 16'h0008), 1'b1, 3, 1);
        chk16(mem_at(AREA_TMR, 16'h0008), 16'h0009);
        chk1(exec_err_q, 1'b0);
        end_of_test;
    end
endmodule // test_plc_advanced_instr_operand_unit
